// ==== common/vhd_pkg.sv ====
// shared constants, field layouts and carrier types of the valve head parameter bank
`default_nettype none
package vhd_pkg;
	// parameter object indices and sub-indices
	localparam logic [15:0] IDX_SERVICE           = 16'h2C04;
	localparam logic [15:0] IDX_DIAG              = 16'h2C06;
	localparam logic [7:0]  SUB_CYC_SERVICE_EN    = 8'h03;
	localparam logic [7:0]  SUB_SETPOINT_REACTION = 8'h08;
	localparam logic [7:0]  SUB_SAFETY_PATTERN    = 8'h09;
	localparam logic [7:0]  SUB_VALVE_VARIANT     = 8'h0A;
	localparam logic [7:0]  SUB_SPARE             = 8'h0B;
	localparam logic [7:0]  SUB_FILTER_SELECT     = 8'h0E;
	localparam logic [7:0]  SUB_LED_OPTION        = 8'h0F;
	localparam logic [7:0]  SUB_BUTTON_LOCK       = 8'h10;
	localparam logic [7:0]  SUB_CYC_LIMIT_ONE     = 8'h11;
	localparam logic [7:0]  SUB_CYC_LIMIT_TWO     = 8'h12;
	localparam logic [7:0]  SUB_CYC_LIMIT_THREE   = 8'h13;
	localparam logic [7:0]  SUB_FAULT_FLAGS       = 8'h01;
	localparam logic [7:0]  SUB_WARNING_FLAGS     = 8'h02;
	// reset values
	localparam logic [7:0]  RST_CYC_SERVICE_EN    = 8'h00;
	localparam logic [7:0]  RST_REACTION          = 8'h00;
	localparam logic [7:0]  RST_PATTERN           = 8'h00;
	localparam logic [7:0]  RST_VARIANT           = 8'h02;
	localparam logic [7:0]  RST_SPARE             = 8'h00;
	localparam logic [7:0]  RST_FILTER            = 8'h00;
	localparam logic [7:0]  RST_LED_OPTION        = 8'h00;
	localparam logic [7:0]  RST_BUTTON_LOCK       = 8'h00;
	localparam logic [31:0] RST_LIMIT_ONE         = 32'h0000_2710;
	localparam logic [31:0] RST_LIMIT_TWO         = 32'h0000_C350;
	localparam logic [31:0] RST_LIMIT_THREE       = 32'h0000_C350;
	// field values
	localparam logic [7:0]  REACT_SAFE_PATTERN    = 8'h00;
	localparam logic [7:0]  REACT_HOLD_LAST       = 8'h01;
	localparam logic [7:0]  LOCK_ACTIVE           = 8'h01;
	localparam logic [7:0]  LED_OPT_ENABLED       = 8'h00;
	localparam logic [7:0]  LED_MODE_VALVE_DIAG   = 8'h03;
	localparam logic [7:0]  LED_MODE_DEV_SPECIFIC = 8'h07;
	localparam logic [7:0]  CYC_SERVICE_ON        = 8'h01;
	localparam logic [7:0]  FILTER_VAL_STANDARD   = 8'h00;
	localparam logic [7:0]  FILTER_VAL_ARRAY      = 8'h01;
	localparam logic [7:0]  FILTER_VAL_SPECIAL    = 8'h02;
	// safety pattern bit positions
	localparam int PAT_SOLENOID_ONE   = 0;
	localparam int PAT_SOLENOID_THREE = 2;
	// fault word bit positions
	localparam int FB_NOT_TAUGHT      = 0;
	localparam int FB_SETPOINT        = 1;
	localparam int FB_TEACH_FAIL      = 5;
	localparam int FB_INT_SENSOR      = 6;
	localparam int FB_EXT_SENSOR      = 7;
	localparam int FB_MEMORY          = 8;
	localparam int FB_SWITCH_TIMEOUT  = 16;
	localparam int FB_SUPPLY_MEAS     = 20;
	localparam int FB_COMMON          = 21;
	localparam int FB_SUPPLY          = 23;
	localparam int FB_TEMPERATURE     = 24;
	// warning word bit positions
	localparam int WB_SAFE_PATTERN    = 1;
	localparam int WB_MAINT_DUE       = 2;
	localparam int WB_INTERNAL_SAFE   = 4;
	localparam int WB_TRAVEL_ACC      = 16;
	localparam int WB_CYCLES          = 17;
	localparam int WB_OP_TIME         = 18;
	localparam int WB_TRAVEL_TIMEOUT  = 19;
	localparam int WB_EXT_MAINT       = 20;
	localparam logic [31:0] FAULT_DEFINED_MASK = 32'h01B1_01E3;
	localparam logic [31:0] WARN_DEFINED_MASK  = 32'h001F_0016;

	typedef enum logic [1:0] {FILTER_STANDARD, FILTER_ARRAY, FILTER_SPECIAL} vhd_filter_t;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic [15:0] index;
		logic [7:0]  sub;
		logic [31:0] wdata;
	} vhd_req_t;

	typedef struct packed {
		logic        ack;
		logic        err;
		logic [31:0] rdata;
	} vhd_resp_t;

	typedef struct packed {
		logic not_taught;
		logic teach_fail;
		logic int_sensor;
		logic ext_sensor;
		logic memory;
		logic switch_timeout;
		logic supply_meas;
		logic common;
		logic supply;
		logic temperature;
	} vhd_fault_in_t;

	typedef struct packed {
		logic travel_acc;
		logic op_time;
		logic travel_timeout;
		logic ext_maint;
		logic time_due;
	} vhd_warn_in_t;
endpackage : vhd_pkg
`default_nettype wire

// ==== rtl/vhd_pin_sync.sv ====
// three-stage pin synchroniser with agreement filter
`default_nettype none
module vhd_pin_sync #(
	parameter int W = 2
) (
	// clock and reset
	input  wire logic         mclk,
	input  wire logic         rst,
	// pins and filtered levels
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] level_out
);
	logic [W-1:0] stage1_reg;
	logic [W-1:0] stage2_reg;
	logic [W-1:0] stage3_reg;

	always_ff @(posedge mclk) begin
		if (rst) begin
			stage1_reg <= '0;
			stage2_reg <= '0;
			stage3_reg <= '0;
		end else begin
			stage1_reg <= pin_in;
			stage2_reg <= stage1_reg;
			stage3_reg <= stage2_reg;
		end
	end

	// a bit only moves once the last two stages agree
	always_ff @(posedge mclk) begin
		if (rst) begin
			level_out <= '0;
		end else begin
			level_out <= (~(stage2_reg ^ stage3_reg) & stage3_reg) | ((stage2_reg ^ stage3_reg) & level_out);
		end
	end
endmodule : vhd_pin_sync
`default_nettype wire

// ==== rtl/vhd_regbank.sv ====
// valve head safety reaction, service display and diagnostic parameter bank
`default_nettype none
module vhd_regbank
	import vhd_pkg::*;
#(
	parameter int VALVES = 3
) (
	// clock and reset
	input  wire logic                     mclk,
	input  wire logic                     rst,
	// on-request parameter access
	input  wire vhd_req_t                 isdu_req,
	output var  vhd_resp_t                isdu_resp,
	// cyclic set-points from the master
	input  wire logic [VALVES-1:0]        process_output_image,
	input  wire logic                     setpoint_error,
	// internal safe state request from the device core
	input  wire logic                     internal_safe_req,
	// condition inputs from the device core
	input  wire vhd_fault_in_t            fault_cond,
	input  wire vhd_warn_in_t             warn_cond,
	input  wire logic [VALVES-1:0][31:0]  cycle_count,
	input  wire logic [7:0]               indicator_mode_setting,
	// local push buttons, pins
	input  wire logic                     teach_button,
	input  wire logic                     reset_button,
	// solenoid drive and indications
	output logic      [VALVES-1:0]        solenoid_out,
	output logic                          service_led,
	output var  vhd_filter_t              position_measuring_system_filter,
	output logic                          teach_press,
	output logic                          reset_press,
	// diagnostic words
	output logic      [31:0]              fault_flags,
	output logic      [31:0]              warning_flags
);
	logic [7:0]              cyc_service_en_reg;
	logic [7:0]              setpoint_error_reaction_reg;
	logic [7:0]              safety_output_pattern_reg;
	logic [7:0]              process_valve_variant_reg;
	logic [7:0]              spare_byte_reg;
	logic [7:0]              position_filter_select_reg;
	logic [7:0]              service_led_option_reg;
	logic [7:0]              button_lock_reg;
	logic [VALVES-1:0][31:0] cycle_limit_reg;
	logic [VALVES-1:0]       last_valid_reg;
	logic [1:0]              button_level;
	logic [1:0]              button_prev_reg;
	logic [VALVES-1:0]       solenoid_next;
	logic                    pattern_drive;
	logic                    cycles_exceeded;
	logic                    maint_due;
	logic [31:0]             fault_next;
	logic [31:0]             warning_next;
	logic                    wr_service;
	logic                    access_diag;
	logic                    access_service;
	logic                    sub_known;
	logic [31:0]             rdata_next;
	logic                    err_next;

	// parameter access decode
	assign access_service = isdu_req.valid && (isdu_req.index == IDX_SERVICE);
	assign access_diag    = isdu_req.valid && (isdu_req.index == IDX_DIAG);
	assign wr_service     = access_service && isdu_req.write && sub_known;
	always_comb begin
		sub_known = 1'b1;
		if (isdu_req.sub == SUB_CYC_SERVICE_EN) begin
			rdata_next = {24'h00_0000, cyc_service_en_reg};
		end else if (isdu_req.sub == SUB_SETPOINT_REACTION) begin
			rdata_next = {24'h00_0000, setpoint_error_reaction_reg};
		end else if (isdu_req.sub == SUB_SAFETY_PATTERN) begin
			rdata_next = {24'h00_0000, safety_output_pattern_reg};
		end else if (isdu_req.sub == SUB_VALVE_VARIANT) begin
			rdata_next = {24'h00_0000, process_valve_variant_reg};
		end else if (isdu_req.sub == SUB_SPARE) begin
			rdata_next = {24'h00_0000, spare_byte_reg};
		end else if (isdu_req.sub == SUB_FILTER_SELECT) begin
			rdata_next = {24'h00_0000, position_filter_select_reg};
		end else if (isdu_req.sub == SUB_LED_OPTION) begin
			rdata_next = {24'h00_0000, service_led_option_reg};
		end else if (isdu_req.sub == SUB_BUTTON_LOCK) begin
			rdata_next = {24'h00_0000, button_lock_reg};
		end else if (isdu_req.sub == SUB_CYC_LIMIT_ONE) begin
			rdata_next = cycle_limit_reg[0];
		end else if (isdu_req.sub == SUB_CYC_LIMIT_TWO) begin
			rdata_next = cycle_limit_reg[1];
		end else if (isdu_req.sub == SUB_CYC_LIMIT_THREE) begin
			rdata_next = cycle_limit_reg[2];
		end else begin
			sub_known  = 1'b0;
			rdata_next = 32'h0000_0000;
		end
		err_next = 1'b0;
		if (access_diag) begin
			if (isdu_req.write) begin
				err_next   = 1'b1;
				rdata_next = 32'h0000_0000;
			end else if (isdu_req.sub == SUB_FAULT_FLAGS) begin
				rdata_next = fault_flags;
			end else if (isdu_req.sub == SUB_WARNING_FLAGS) begin
				rdata_next = warning_flags;
			end else begin
				err_next   = 1'b1;
				rdata_next = 32'h0000_0000;
			end
		end else if (access_service) begin
			err_next = !sub_known;
			if (isdu_req.write) begin
				rdata_next = 32'h0000_0000;
			end
		end else begin
			err_next   = 1'b1;
			rdata_next = 32'h0000_0000;
		end
	end
	// answer follows each request by exactly one cycle
	always_ff @(posedge mclk) begin
		if (rst) begin
			isdu_resp <= '0;
		end else begin
			isdu_resp.ack   <= isdu_req.valid;
			isdu_resp.err   <= isdu_req.valid && err_next;
			isdu_resp.rdata <= isdu_req.valid ? rdata_next : 32'h0000_0000;
		end
	end

	// byte parameters
	always_ff @(posedge mclk) begin
		if (rst) begin
			cyc_service_en_reg          <= RST_CYC_SERVICE_EN;
			setpoint_error_reaction_reg <= RST_REACTION;
			safety_output_pattern_reg   <= RST_PATTERN;
			process_valve_variant_reg   <= RST_VARIANT;
			spare_byte_reg              <= RST_SPARE;
			position_filter_select_reg  <= RST_FILTER;
			service_led_option_reg      <= RST_LED_OPTION;
			button_lock_reg             <= RST_BUTTON_LOCK;
		end else if (wr_service) begin
			if (isdu_req.sub == SUB_CYC_SERVICE_EN) begin
				cyc_service_en_reg <= isdu_req.wdata[7:0];
			end else if (isdu_req.sub == SUB_SETPOINT_REACTION) begin
				setpoint_error_reaction_reg <= isdu_req.wdata[7:0];
			end else if (isdu_req.sub == SUB_SAFETY_PATTERN) begin
				safety_output_pattern_reg <= isdu_req.wdata[7:0];
			end else if (isdu_req.sub == SUB_VALVE_VARIANT) begin
				process_valve_variant_reg <= isdu_req.wdata[7:0];
			end else if (isdu_req.sub == SUB_SPARE) begin
				spare_byte_reg <= isdu_req.wdata[7:0];
			end else if (isdu_req.sub == SUB_FILTER_SELECT) begin
				position_filter_select_reg <= isdu_req.wdata[7:0];
			end else if (isdu_req.sub == SUB_LED_OPTION) begin
				service_led_option_reg <= isdu_req.wdata[7:0];
			end else if (isdu_req.sub == SUB_BUTTON_LOCK) begin
				button_lock_reg <= isdu_req.wdata[7:0];
			end
		end
	end
	// per-valve cycle limits
	always_ff @(posedge mclk) begin
		if (rst) begin
			cycle_limit_reg[0] <= RST_LIMIT_ONE;
			cycle_limit_reg[1] <= RST_LIMIT_TWO;
			cycle_limit_reg[2] <= RST_LIMIT_THREE;
		end else if (wr_service) begin
			if (isdu_req.sub == SUB_CYC_LIMIT_ONE) begin
				cycle_limit_reg[0] <= isdu_req.wdata;
			end else if (isdu_req.sub == SUB_CYC_LIMIT_TWO) begin
				cycle_limit_reg[1] <= isdu_req.wdata;
			end else if (isdu_req.sub == SUB_CYC_LIMIT_THREE) begin
				cycle_limit_reg[2] <= isdu_req.wdata;
			end
		end
	end

	// solenoid drive; set-points are only captured while the link is healthy
	always_ff @(posedge mclk) begin
		if (rst) begin
			last_valid_reg <= '0;
		end else if (!setpoint_error) begin
			last_valid_reg <= process_output_image;
		end
	end
	// unknown reaction codes fall back to the pattern, the safer choice
	assign pattern_drive = setpoint_error && !internal_safe_req
		&& (setpoint_error_reaction_reg != REACT_HOLD_LAST);
	always_comb begin
		if (internal_safe_req) begin
			solenoid_next = '0;
		end else if (!setpoint_error) begin
			solenoid_next = process_output_image;
		end else if (setpoint_error_reaction_reg == REACT_HOLD_LAST) begin
			solenoid_next = last_valid_reg;
		end else begin
			solenoid_next = safety_output_pattern_reg[PAT_SOLENOID_THREE:PAT_SOLENOID_ONE];
		end
	end
	always_ff @(posedge mclk) begin
		if (rst) begin
			solenoid_out <= '0;
		end else begin
			solenoid_out <= solenoid_next;
		end
	end

	// filter select, out-of-range values keep standard filtering
	always_ff @(posedge mclk) begin
		if (rst) begin
			position_measuring_system_filter <= FILTER_STANDARD;
		end else if (position_filter_select_reg == FILTER_VAL_ARRAY) begin
			position_measuring_system_filter <= FILTER_ARRAY;
		end else if (position_filter_select_reg == FILTER_VAL_SPECIAL) begin
			position_measuring_system_filter <= FILTER_SPECIAL;
		end else begin
			position_measuring_system_filter <= FILTER_STANDARD;
		end
	end

	// maintenance and service indication
	always_comb begin
		cycles_exceeded = 1'b0;
		for (int i = 0; i < VALVES; i++) begin
			if (cycle_count[i] > cycle_limit_reg[i]) begin
				cycles_exceeded = 1'b1;
			end
		end
	end
	assign maint_due = ((cyc_service_en_reg == CYC_SERVICE_ON) && cycles_exceeded) || warn_cond.time_due;
	always_ff @(posedge mclk) begin
		if (rst) begin
			service_led <= 1'b0;
		end else begin
			service_led <= maint_due && (service_led_option_reg == LED_OPT_ENABLED)
				&& ((indicator_mode_setting == LED_MODE_VALVE_DIAG)
				|| (indicator_mode_setting == LED_MODE_DEV_SPECIFIC));
		end
	end

	// local buttons: synchronised, then one pulse per press
	vhd_pin_sync #(
		.W(2)
	) u_button_sync (
		.mclk     (mclk),
		.rst      (rst),
		.pin_in   ({reset_button, teach_button}),
		.level_out(button_level)
	);
	always_ff @(posedge mclk) begin
		if (rst) begin
			button_prev_reg <= 2'h0;
			teach_press     <= 1'b0;
			reset_press     <= 1'b0;
		end else begin
			button_prev_reg <= button_level;
			teach_press     <= button_level[0] && !button_prev_reg[0] && (button_lock_reg != LOCK_ACTIVE);
			reset_press     <= button_level[1] && !button_prev_reg[1] && (button_lock_reg != LOCK_ACTIVE);
		end
	end

	// diagnostic words, rebuilt every cycle from live conditions
	always_comb begin
		fault_next = 32'h0000_0000;
		fault_next[FB_NOT_TAUGHT]     = fault_cond.not_taught;
		fault_next[FB_SETPOINT]       = setpoint_error;
		fault_next[FB_TEACH_FAIL]     = fault_cond.teach_fail;
		fault_next[FB_INT_SENSOR]     = fault_cond.int_sensor;
		fault_next[FB_EXT_SENSOR]     = fault_cond.ext_sensor;
		fault_next[FB_MEMORY]         = fault_cond.memory;
		fault_next[FB_SWITCH_TIMEOUT] = fault_cond.switch_timeout;
		fault_next[FB_SUPPLY_MEAS]    = fault_cond.supply_meas;
		fault_next[FB_COMMON]         = fault_cond.common;
		fault_next[FB_SUPPLY]         = fault_cond.supply;
		fault_next[FB_TEMPERATURE]    = fault_cond.temperature;
	end
	always_comb begin
		warning_next = 32'h0000_0000;
		warning_next[WB_SAFE_PATTERN]   = pattern_drive;
		warning_next[WB_MAINT_DUE]      = maint_due;
		warning_next[WB_INTERNAL_SAFE]  = internal_safe_req;
		warning_next[WB_TRAVEL_ACC]     = warn_cond.travel_acc;
		warning_next[WB_CYCLES]         = cycles_exceeded;
		warning_next[WB_OP_TIME]        = warn_cond.op_time;
		warning_next[WB_TRAVEL_TIMEOUT] = warn_cond.travel_timeout;
		warning_next[WB_EXT_MAINT]      = warn_cond.ext_maint;
	end
	// no write path reaches these words
	always_ff @(posedge mclk) begin
		if (rst) begin
			fault_flags   <= 32'h0000_0000;
			warning_flags <= 32'h0000_0000;
		end else begin
			fault_flags   <= fault_next;
			warning_flags <= warning_next;
		end
	end

	// checks
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);
	chk_safe_pattern_drive: assert property (
		setpoint_error && !internal_safe_req && (setpoint_error_reaction_reg == REACT_SAFE_PATTERN)
		|=> (solenoid_out == $past(safety_output_pattern_reg[2:0])) && warning_flags[WB_SAFE_PATTERN])
		else $error("safety pattern not applied on set-point error");
	chk_hold_last_setpoint: assert property (
		!setpoint_error ##1 (setpoint_error && !internal_safe_req
		&& (setpoint_error_reaction_reg == REACT_HOLD_LAST)) [*2]
		|=> solenoid_out == $past(process_output_image, 3))
		else $error("last valid set-point not held");
	chk_internal_safe_off: assert property (
		internal_safe_req |=> (solenoid_out == '0) && warning_flags[WB_INTERNAL_SAFE]
		&& !warning_flags[WB_SAFE_PATTERN])
		else $error("internal safe state did not force outputs off");
	chk_filter_select_map: assert property (
		(position_filter_select_reg == FILTER_VAL_SPECIAL) |=> position_measuring_system_filter == FILTER_SPECIAL)
		else $error("special filter not selected");
	chk_led_option_gate: assert property (
		service_led |-> $past(maint_due && (service_led_option_reg == LED_OPT_ENABLED)
		&& (indicator_mode_setting == LED_MODE_VALVE_DIAG || indicator_mode_setting == LED_MODE_DEV_SPECIFIC)))
		else $error("service LED lit outside its modes");
	chk_button_lock_hold: assert property (
		(button_lock_reg == LOCK_ACTIVE) |=> !teach_press && !reset_press)
		else $error("button press passed while locked");
	chk_cycle_due_flag: assert property (
		(cyc_service_en_reg == CYC_SERVICE_ON) && (cycle_count[2] > cycle_limit_reg[2])
		|=> warning_flags[WB_MAINT_DUE] && warning_flags[WB_CYCLES])
		else $error("maintenance due not raised for valve three");
	chk_diag_write_refused: assert property (
		access_diag && isdu_req.write |=> isdu_resp.ack && isdu_resp.err)
		else $error("write to diagnostic word not refused");
	chk_reserved_bits_zero: assert property (
		(((fault_flags & ~FAULT_DEFINED_MASK) | (warning_flags & ~WARN_DEFINED_MASK)) == 32'h0000_0000))
		else $error("reserved diagnostic bit set");
	chk_setpoint_flag_track: assert property (
		$fell(setpoint_error) |=> !fault_flags[FB_SETPOINT] && $past(fault_flags[FB_SETPOINT]))
		else $error("set-point fault flag did not follow its condition");
	chk_answer_timing: assert property (
		isdu_req.valid |=> isdu_resp.ack ##1 (isdu_resp.ack == $past(isdu_req.valid)))
		else $error("answer not one cycle after request");
	chk_limit_write_read: assert property (
		wr_service && (isdu_req.sub == SUB_CYC_LIMIT_TWO) |=> cycle_limit_reg[1] == $past(isdu_req.wdata))
		else $error("cycle limit two not written");
	cov_safe_pattern: cover property (setpoint_error && pattern_drive ##1 solenoid_out != '0);
	cov_hold_last: cover property (setpoint_error && (setpoint_error_reaction_reg == REACT_HOLD_LAST) [*3]);
	cov_led_lit: cover property ($rose(service_led));
	cov_locked_press: cover property ((button_lock_reg == LOCK_ACTIVE) && button_level[0] && !button_prev_reg[0]);
endmodule : vhd_regbank
`default_nettype wire

// ==== bench/vhd_master_model.sv ====
// master model: parameter requests and cyclic process data
`default_nettype none
module vhd_master_model
	import vhd_pkg::*;
(
	// clock
	input  wire logic       mclk,
	// parameter access
	output var  vhd_req_t   req,
	input  wire vhd_resp_t  resp,
	// process data
	output var  logic [2:0] pd,
	output var  logic       pd_err
);
	timeunit 1ns;
	timeprecision 1ns;
	initial {req, pd, pd_err} = '0;
	// one strobe only: a held valid would count as a second request;
	// the idle cycle after it keeps valid from dropping and rising in one step
	task automatic xfer(input logic w, input logic [15:0] ix, input logic [7:0] sb, input logic [31:0] wd,
		output vhd_resp_t r);
		req = '{1'b1, w, ix, sb, wd};
		@(negedge mclk);
		r = resp;
		req = '0;
		@(negedge mclk);
	endtask : xfer
	task automatic pdata(input logic [2:0] v, input logic e);
		pd = v;
		pd_err = e;
	endtask : pdata
endmodule : vhd_master_model
`default_nettype wire

// ==== bench/tb_top.sv ====
// self-checking bench of the valve head parameter bank
`default_nettype none
module tb_top import vhd_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	vhd_req_t req;
	vhd_resp_t resp, r;
	logic [2:0] pd, sol;
	logic pd_err, isafe, tbtn, rbtn, led, tpr, rpr;
	vhd_fault_in_t fc;
	vhd_warn_in_t wc;
	logic [2:0][31:0] cnt;
	logic [7:0] ledm;
	logic [31:0] ff, wf;
	vhd_filter_t filt;
	int bad_count = 0;
	int samples_checked = 0;
	int fp[10] = '{0, 5, 6, 7, 8, 16, 20, 21, 23, 24};
	int wp[5] = '{16, 18, 19, 20, 2};
	always #20 mclk = ~mclk;
	vhd_master_model master (.mclk, .req, .resp, .pd, .pd_err);
	vhd_regbank dut (.mclk, .rst, .isdu_req(req), .isdu_resp(resp), .process_output_image(pd),
		.setpoint_error(pd_err), .internal_safe_req(isafe), .fault_cond(fc), .warn_cond(wc), .cycle_count(cnt),
		.indicator_mode_setting(ledm), .teach_button(tbtn), .reset_button(rbtn), .solenoid_out(sol),
		.service_led(led), .position_measuring_system_filter(filt), .teach_press(tpr), .reset_press(rpr),
		.fault_flags(ff), .warning_flags(wf));
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wt(input int n);
		repeat (n) @(negedge mclk);
	endtask : wt
	task automatic acc(input logic w, input logic [15:0] ix, input logic [7:0] sb, input logic [31:0] wd,
		input logic ee, input logic [31:0] er);
		master.xfer(w, ix, sb, wd, r);
		chk("ack_err", {30'h0, 1'b1, ee}, {30'h0, r.ack, r.err});
		chk("rdata", er, r.rdata);
	endtask : acc
	task automatic press(input logic [31:0] e);
		int n;
		n = 0;
		{tbtn, rbtn} = 2'h3;
		for (int k = 0; k < 12; k++) begin
			wt(1);
			n += tpr + rpr;
		end
		{tbtn, rbtn} = 2'h0;
		wt(6);
		chk("presses", e, n);
	endtask : press
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : tally_and_finish
	initial begin
		{isafe, tbtn, rbtn, fc, wc, cnt, ledm} = '0;
		wt(20);
		rst = 1'b0;
		wt(1);
		acc(0, 16'h2C04, 8'h11, 0, 0, 32'h0000_2710);
		acc(0, 16'h2C04, 8'h13, 0, 0, 32'h0000_C350);
		acc(1, 16'h2C04, 8'h12, 32'hFFFF_FFFF, 0, 0);
		acc(0, 16'h2C04, 8'h12, 0, 0, 32'hFFFF_FFFF);
		acc(1, 16'h2C06, 8'h02, 32'hFFFF_FFFF, 1, 0);
		acc(0, 16'h2C06, 8'h02, 0, 0, 0);
		$display("test registers done");
		acc(1, 16'h2C04, 8'h09, 32'h0000_00FB, 0, 0);
		master.pdata(3'h2, 1'b1);
		wt(2);
		chk("solenoids", 32'h3, {29'h0, sol});
		chk("warnings", 32'h2, wf);
		chk("faults", 32'h2, ff);
		master.pdata(3'h6, 1'b0);
		acc(1, 16'h2C04, 8'h08, 32'h1, 0, 0);
		master.pdata(3'h1, 1'b1);
		wt(2);
		chk("solenoids", 32'h6, {29'h0, sol});
		chk("warnings", 32'h0, wf);
		isafe = 1'b1;
		wt(2);
		chk("solenoids", 32'h0, {29'h0, sol});
		chk("warnings", 32'h10, wf);
		isafe = 1'b0;
		master.pdata(3'h0, 1'b0);
		$display("test solenoids done");
		for (int i = 0; i < 10; i++) begin
			fc = 10'h200 >> i;
			wt(2);
			chk("faults", 32'h1 << fp[i], ff);
		end
		fc = '0;
		ledm = 8'h07;
		for (int i = 0; i < 5; i++) begin
			wc = 5'h10 >> i;
			wt(2);
			chk("warnings", 32'h1 << wp[i], wf);
			chk("led", {31'h0, i == 4}, {31'h0, led});
		end
		acc(1, 16'h2C04, 8'h0F, 32'h1, 0, 0);
		wt(2);
		chk("led", 32'h0, {31'h0, led});
		wc = '0;
		wt(2);
		chk("warnings", 32'h0, wf);
		acc(1, 16'h2C04, 8'h03, 32'h1, 0, 0);
		cnt[2] = 32'h0000_C350;
		wt(2);
		chk("warnings", 32'h0, wf);
		cnt[2] = 32'h0000_C351;
		wt(2);
		chk("warnings", 32'h0002_0004, wf);
		$display("test diagnostics done");
		for (int i = 0; i < 3; i++) begin
			acc(1, 16'h2C04, 8'h0E, i, 0, 0);
			wt(2);
			chk("filter", i, {30'h0, filt});
		end
		acc(1, 16'h2C04, 8'h10, 32'h1, 0, 0);
		press(0);
		acc(1, 16'h2C04, 8'h10, 32'h0, 0, 0);
		press(2);
		$display("test filter and lock done");
		tally_and_finish();
	end
endmodule : tb_top
`default_nettype wire
